// *** core/swc_map.svh ***
`ifndef SWC_MAP_SVH
`define SWC_MAP_SVH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define SWC_ADDR_W 8
`define SWC_OFF_CTRL 8'h00
`define SWC_OFF_CMD 8'h04
`define SWC_OFF_STATUS 8'h08
`define SWC_OFF_BACKUP 8'h0C

// ---------------------------------------------------------------
// Control register fields
// ---------------------------------------------------------------
`define SWC_CTRL_W 8
`define SWC_CTRL_RST 8'h00
`define SWC_F_SEL_LO 0
`define SWC_F_SEL_HI 1
`define SWC_F_WU_LO 2
`define SWC_F_WU_HI 3
`define SWC_F_DRIVE 4
`define SWC_F_SLOW 5
`define SWC_F_HOSC_STOP 6
`define SWC_F_PHASE_MODE 7
`define SWC_CMD_ENTER 0

// ---------------------------------------------------------------
// Standby kinds in the select field
// ---------------------------------------------------------------
`define SWC_SEL_IDLE 2'h0
`define SWC_SEL_SLEEP 2'h1
`define SWC_SEL_STOP 2'h2

// ---------------------------------------------------------------
// Warm-up lengths as powers of two of oscillator cycles
// ---------------------------------------------------------------
`define SWC_WU_CNT_W 17
`define SWC_WU_EXP_01 8
`define SWC_WU_EXP_10 14
`define SWC_WU_EXP_11 16

// ---------------------------------------------------------------
// Status register fields
// ---------------------------------------------------------------
`define SWC_ST_MODE_LO 0
`define SWC_ST_MODE_HI 4
`define SWC_ST_SLOW 5
`define SWC_ST_HOSC 6
`define SWC_ST_BY_RESET 7
`define SWC_ST_BY_IRQ 8
`define SWC_ST_WU_DONE 9

`endif

// *** core/swc_pkg.sv ***
package swc_pkg;

	// Operating states, one-hot
	typedef enum logic [4:0] {
		SWC_RUN = 5'h01,
		SWC_IDLE = 5'h02,
		SWC_SLEEP = 5'h04,
		SWC_STOP = 5'h08,
		SWC_WARM = 5'h10
	} swc_state_t;

endpackage : swc_pkg

// *** core/swc_standby_ctrl.sv ***
// How it works
// - Reset ends any standby state
// - Reset exit keeps backup data, clears settings
// - Interrupt exit keeps all state untouched
// - Wake with interrupts enabled runs handler
// - Wake with interrupts disabled resumes next instruction
// - Wake sources qualified per standby kind
// - STOP wake completes after warm-up
// - Phase counter wakes SLEEP only in phase mode
// - Only level above mask wakes the block
// - STOP halts oscillators and internal clocks, except the low-speed clock when entered from SLOW
// - STOP pin states follow drive enable
// - System clock gated until warm-up done
// - STOP returns to prior NORMAL or SLOW
// - Warm-up select gives 2^8, 2^14, 2^16
// - Warm-up only on SLEEP/STOP/SLOW to NORMAL
// - SLOW through STOP needs no warm-up
//
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/100ps
`include "swc_map.svh"

module swc_standby_ctrl #(
	parameter int WU_SCALE_SHIFT = 0
) (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic srst_i,
	// APB slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [`SWC_ADDR_W-1:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Pins
	input wire logic ext_rst_n_i,
	input wire logic osc_clk_i,
	input wire logic [11:0] external_irq_lines_i,
	input wire logic [7:0] key_wake_inputs_i,
	// Wake sources from on-chip logic
	input wire logic watchdog_irq_i,
	input wire logic [9:0] timer_irqs_i,
	input wire logic [6:0] serial_rx_irqs_i,
	input wire logic serial_bus_irq_i,
	input wire logic converter_irq_i,
	input wire logic clock_timer_irq_i,
	input wire logic phase_counter_irq_i,
	// Processor core
	input wire logic cpu_interrupt_enable_i,
	input wire logic [2:0] irq_level_i,
	input wire logic [2:0] irq_mask_i,
	output logic take_handler_o,
	output logic resume_next_o,
	output logic settings_init_o,
	// Clock and pin control
	output logic sys_clk_en_o,
	output logic hosc_run_o,
	output logic low_speed_clock_run_o,
	output logic pin_drive_hold_o,
	output logic pin_float_o,
	output swc_pkg::swc_state_t mode_o
);

	import swc_pkg::*;

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	logic [21:0] pins_sync;
	logic ext_rst_n_s;
	logic osc_s;
	logic [11:0] ext_irq_s;
	logic [7:0] key_s;

	swc_sync #(
		.WIDTH(22),
		.RST_VAL(22'h200000)
	) u_sync (
		.core_clk_i(core_clk_i),
		.srst_i(srst_i),
		.async_i({ext_rst_n_i, osc_clk_i, external_irq_lines_i, key_wake_inputs_i}),
		.sync_o(pins_sync)
	);

	assign ext_rst_n_s = pins_sync[21];
	assign osc_s = pins_sync[20];
	assign ext_irq_s = pins_sync[19:8];
	assign key_s = pins_sync[7:0];

	// Oscillator edge as one-cycle tick
	logic osc_d_r;
	logic osc_tick;

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			osc_d_r <= 1'b0;
		end else begin
			osc_d_r <= osc_s;
		end
	end

	assign osc_tick = osc_s && !osc_d_r;

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	logic [`SWC_CTRL_W-1:0] ctrl_r;
	logic [31:0] backup_r;
	logic enter_req;
	logic apb_wr;
	logic apb_setup;
	logic ext_rst;
	logic [1:0] stby_sel;
	logic [1:0] wu_sel;
	logic drive_en;
	logic slow_sel;
	logic hosc_stop;
	logic phase_mode;

	assign apb_setup = psel_i && !penable_i;
	assign apb_wr = psel_i && penable_i && pready_o && pwrite_i;
	assign ext_rst = !ext_rst_n_s;
	assign stby_sel = ctrl_r[`SWC_F_SEL_HI:`SWC_F_SEL_LO];
	assign wu_sel = ctrl_r[`SWC_F_WU_HI:`SWC_F_WU_LO];
	assign drive_en = ctrl_r[`SWC_F_DRIVE];
	assign slow_sel = ctrl_r[`SWC_F_SLOW];
	assign hosc_stop = ctrl_r[`SWC_F_HOSC_STOP];
	assign phase_mode = ctrl_r[`SWC_F_PHASE_MODE];
	assign enter_req = apb_wr && (paddr_i == `SWC_OFF_CMD) && pwdata_i[`SWC_CMD_ENTER];

	// Settings cleared by a reset exit, held across an interrupt exit
	always_ff @(posedge core_clk_i) begin
		if (srst_i || ext_rst) begin
			ctrl_r <= `SWC_CTRL_RST;
		end else if (apb_wr && paddr_i == `SWC_OFF_CTRL) begin
			ctrl_r <= pwdata_i[`SWC_CTRL_W-1:0];
		end
	end

	// Backup data survives the pin reset
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			backup_r <= 32'h00000000;
		end else if (apb_wr && paddr_i == `SWC_OFF_BACKUP) begin
			backup_r <= pwdata_i;
		end
	end

	// ---------------------------------------------------------------
	// Wake qualification
	// ---------------------------------------------------------------
	logic level_ok;
	logic pin_src;
	logic sleep_src;
	logic idle_src;
	logic wake_idle;
	logic wake_sleep;
	logic wake_stop;

	assign level_ok = irq_level_i > irq_mask_i;
	assign pin_src = |ext_irq_s || |key_s;
	assign sleep_src = pin_src || clock_timer_irq_i || (phase_counter_irq_i && phase_mode);
	assign idle_src = sleep_src || watchdog_irq_i || |timer_irqs_i || |serial_rx_irqs_i
		|| serial_bus_irq_i || converter_irq_i || phase_counter_irq_i;
	assign wake_idle = idle_src && level_ok;
	assign wake_sleep = sleep_src && level_ok;
	assign wake_stop = pin_src && level_ok;

	// ---------------------------------------------------------------
	// Mode state machine
	// ---------------------------------------------------------------
	swc_state_t state_r;
	swc_state_t state_nxt;
	logic slow_active_r;
	logic hosc_off_r;
	logic wu_start;
	logic wu_done;
	logic release_ev;
	logic warm_to_slow_r;
	logic warm_to_slow_nxt;

	always_comb begin
		state_nxt = state_r;
		wu_start = 1'b0;
		release_ev = 1'b0;
		warm_to_slow_nxt = warm_to_slow_r;
		case (state_r)
			SWC_RUN: begin
				if (enter_req) begin
					case (stby_sel)
						`SWC_SEL_IDLE: state_nxt = SWC_IDLE;
						`SWC_SEL_SLEEP: state_nxt = SWC_SLEEP;
						`SWC_SEL_STOP: state_nxt = SWC_STOP;
						default: state_nxt = SWC_RUN;
					endcase
				end else if (slow_active_r && !slow_sel && hosc_off_r) begin
					state_nxt = SWC_WARM;
					warm_to_slow_nxt = 1'b0;
					wu_start = 1'b1;
				end
			end
			SWC_IDLE: begin
				if (wake_idle) begin
					state_nxt = SWC_RUN;
					release_ev = 1'b1;
				end
			end
			SWC_SLEEP: begin
				if (wake_sleep && slow_active_r) begin
					state_nxt = SWC_RUN;
					release_ev = 1'b1;
				end else if (wake_sleep) begin
					state_nxt = SWC_WARM;
					warm_to_slow_nxt = 1'b0;
					wu_start = 1'b1;
				end
			end
			SWC_STOP: begin
				if (wake_stop && slow_active_r) begin
					state_nxt = SWC_RUN;
					release_ev = 1'b1;
				end else if (wake_stop) begin
					state_nxt = SWC_WARM;
					warm_to_slow_nxt = 1'b0;
					wu_start = 1'b1;
				end
			end
			SWC_WARM: begin
				if (wu_done && !wu_start) begin
					state_nxt = SWC_RUN;
					release_ev = 1'b1;
				end
			end
			default: begin
				state_nxt = SWC_RUN;
			end
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (srst_i || ext_rst) begin
			state_r <= SWC_RUN;
		end else begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (srst_i || ext_rst) begin
			warm_to_slow_r <= 1'b0;
		end else begin
			warm_to_slow_r <= warm_to_slow_nxt;
		end
	end

	// Active run mode only follows the select bit while running
	always_ff @(posedge core_clk_i) begin
		if (srst_i || ext_rst) begin
			slow_active_r <= 1'b0;
		end else if (state_r == SWC_RUN && state_nxt == SWC_RUN) begin
			slow_active_r <= slow_sel;
		end else if (state_r == SWC_WARM && state_nxt == SWC_RUN) begin
			slow_active_r <= warm_to_slow_r;
		end
	end

	// High-speed oscillator status, off in SLOW when stopped by software
	always_ff @(posedge core_clk_i) begin
		if (srst_i || ext_rst) begin
			hosc_off_r <= 1'b0;
		end else if (state_r == SWC_RUN && slow_active_r && hosc_stop) begin
			hosc_off_r <= 1'b1;
		end else if (state_r == SWC_WARM && state_nxt == SWC_RUN) begin
			hosc_off_r <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Warm-up counter
	// ---------------------------------------------------------------
	swc_warmup #(
		.SCALE_SHIFT(WU_SCALE_SHIFT)
	) u_warmup (
		.core_clk_i(core_clk_i),
		.srst_i(srst_i),
		.start_i(wu_start),
		.tick_i(osc_tick),
		.sel_i(wu_sel),
		.done_o(wu_done)
	);

	// ---------------------------------------------------------------
	// Release outcome toward the core
	// ---------------------------------------------------------------
	logic by_reset_r;
	logic by_irq_r;
	logic ext_rst_d_r;
	logic stby_any;

	assign stby_any = state_r != SWC_RUN;

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			take_handler_o <= 1'b0;
			resume_next_o <= 1'b0;
		end else begin
			take_handler_o <= release_ev && cpu_interrupt_enable_i;
			resume_next_o <= release_ev && !cpu_interrupt_enable_i;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			ext_rst_d_r <= 1'b0;
		end else begin
			ext_rst_d_r <= ext_rst;
		end
	end

	// One pulse as the pin reset lifts
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			settings_init_o <= 1'b0;
		end else begin
			settings_init_o <= ext_rst_d_r && !ext_rst;
		end
	end

	// Cause of the last exit; new standby entry clears it
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			by_reset_r <= 1'b0;
			by_irq_r <= 1'b0;
		end else if (ext_rst) begin
			by_reset_r <= stby_any || by_reset_r;
			by_irq_r <= 1'b0;
		end else if (release_ev) begin
			by_reset_r <= 1'b0;
			by_irq_r <= 1'b1;
		end else if (enter_req) begin
			by_reset_r <= 1'b0;
			by_irq_r <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Clock and pin control
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			sys_clk_en_o <= 1'b1;
			hosc_run_o <= 1'b1;
			low_speed_clock_run_o <= 1'b1;
			pin_drive_hold_o <= 1'b0;
			pin_float_o <= 1'b0;
			mode_o <= SWC_RUN;
		end else begin
			sys_clk_en_o <= state_nxt == SWC_RUN;
			hosc_run_o <= !(state_nxt == SWC_STOP || state_nxt == SWC_SLEEP)
				&& !(state_nxt == SWC_RUN && slow_active_r && hosc_stop);
			low_speed_clock_run_o <= state_nxt != SWC_STOP || slow_active_r;
			pin_drive_hold_o <= state_nxt == SWC_STOP && drive_en;
			pin_float_o <= state_nxt == SWC_STOP && !drive_en;
			mode_o <= state_nxt;
		end
	end

	// ---------------------------------------------------------------
	// APB slave, zero wait states
	// ---------------------------------------------------------------
	logic addr_ok;
	logic [31:0] rd_mux;

	assign addr_ok = paddr_i == `SWC_OFF_CTRL || paddr_i == `SWC_OFF_CMD
		|| paddr_i == `SWC_OFF_STATUS || paddr_i == `SWC_OFF_BACKUP;

	always_comb begin
		rd_mux = 32'h00000000;
		case (paddr_i)
			`SWC_OFF_CTRL: rd_mux[`SWC_CTRL_W-1:0] = ctrl_r;
			`SWC_OFF_STATUS: begin
				rd_mux[`SWC_ST_MODE_HI:`SWC_ST_MODE_LO] = state_r;
				rd_mux[`SWC_ST_SLOW] = slow_active_r;
				rd_mux[`SWC_ST_HOSC] = !hosc_off_r;
				rd_mux[`SWC_ST_BY_RESET] = by_reset_r;
				rd_mux[`SWC_ST_BY_IRQ] = by_irq_r;
				rd_mux[`SWC_ST_WU_DONE] = wu_done;
			end
			`SWC_OFF_BACKUP: rd_mux = backup_r;
			default: rd_mux = 32'h00000000;
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o <= 32'h00000000;
		end else if (apb_setup) begin
			pready_o <= 1'b1;
			pslverr_o <= !addr_ok || (!pwrite_i && paddr_i == `SWC_OFF_CMD);
			prdata_o <= pwrite_i ? 32'h00000000 : rd_mux;
		end else begin
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
		end
	end

endmodule : swc_standby_ctrl

// *** core/swc_sync.sv ***
`timescale 1ns/100ps

module swc_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic srst_i,
	// Data
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] sync_r;

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			meta_r <= RST_VAL;
			sync_r <= RST_VAL;
		end else begin
			meta_r <= async_i;
			sync_r <= meta_r;
		end
	end

	assign sync_o = sync_r;

endmodule : swc_sync

// *** core/swc_warmup.sv ***
`timescale 1ns/100ps
`include "swc_map.svh"

module swc_warmup #(
	parameter int SCALE_SHIFT = 0
) (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic srst_i,
	// Control
	input wire logic start_i,
	input wire logic tick_i,
	input wire logic [1:0] sel_i,
	// Status
	output logic done_o
);

	logic [`SWC_WU_CNT_W-1:0] cnt_r;
	logic [`SWC_WU_CNT_W-1:0] term;
	logic [`SWC_WU_CNT_W-1:0] scaled;

	// Terminal count of oscillator cycles for a selection
	function automatic logic [`SWC_WU_CNT_W-1:0] wu_term(input logic [1:0] sel);
		logic [`SWC_WU_CNT_W-1:0] one;
		one = `SWC_WU_CNT_W'(1);
		case (sel)
			2'h2: wu_term = one << `SWC_WU_EXP_10;
			2'h3: wu_term = one << `SWC_WU_EXP_11;
			default: wu_term = one << `SWC_WU_EXP_01;
		endcase
	endfunction : wu_term

	// Scaled count never drops below one tick
	assign scaled = wu_term(sel_i) >> SCALE_SHIFT;
	assign term = (scaled == '0) ? `SWC_WU_CNT_W'(1) : scaled;

	always_ff @(posedge core_clk_i) begin
		if (srst_i || start_i) begin
			cnt_r <= '0;
		end else if (tick_i && !done_o) begin
			cnt_r <= cnt_r + `SWC_WU_CNT_W'(1);
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (srst_i || start_i) begin
			done_o <= 1'b0;
		end else if (tick_i && (cnt_r + `SWC_WU_CNT_W'(1) >= term)) begin
			done_o <= 1'b1;
		end
	end

endmodule : swc_warmup

// *** testbench/standby_wakeup_warmup_control_test.sv ***
`timescale 1ns/100ps
`include "swc_map.svh"

module standby_wakeup_warmup_control_test;
	import swc_pkg::*;
	logic clk = 0;
	logic srst = 1;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic ext_rst_n = 1;
	logic ie = 1;
	logic [2:0] lvl = 3'h3;
	logic [2:0] msk = 3'h1;
	logic raise = 0;
	logic [3:0] src = 0;
	logic wl;
	logic osc;
	logic take;
	logic resume;
	logic init;
	logic sclk;
	logic hosc;
	logic lsc;
	logic hold;
	logic flt;
	swc_state_t mode;
	logic [8:0] hit;
	logic [31:0] rd;
	logic e;
	int fails = 0;
	int compares = 0;
	int cyc = 0;
	int n;

	assign hit = wl ? (9'h001 << src) : 9'h000;

	swc_standby_ctrl #(.WU_SCALE_SHIFT(6)) DUT (.core_clk_i(clk), .srst_i(srst), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .ext_rst_n_i(ext_rst_n), .osc_clk_i(osc), .external_irq_lines_i({11'h000, hit[0]}),
		.key_wake_inputs_i({7'h00, hit[1]}), .watchdog_irq_i(hit[2]), .timer_irqs_i({9'h000, hit[3]}),
		.serial_rx_irqs_i({6'h00, hit[4]}), .serial_bus_irq_i(hit[5]), .converter_irq_i(hit[6]),
		.clock_timer_irq_i(hit[7]), .phase_counter_irq_i(hit[8]), .cpu_interrupt_enable_i(ie), .irq_level_i(lvl),
		.irq_mask_i(msk), .take_handler_o(take), .resume_next_o(resume), .settings_init_o(init),
		.sys_clk_en_o(sclk), .hosc_run_o(hosc), .low_speed_clock_run_o(lsc), .pin_drive_hold_o(hold),
		.pin_float_o(flt), .mode_o(mode));

	swc_core_model u_core (.core_clk_i(clk), .srst_i(srst), .raise_i(raise), .take_handler_i(take),
		.resume_next_i(resume), .osc_clk_o(osc), .wake_level_o(wl));

	initial forever #2.5 clk = ~clk;

	// ---------------------------------------------------------------
	// Shared tasks
	// ---------------------------------------------------------------
	task automatic wrap_up();
		$display("compares=%0d fails=%0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : wrap_up

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int k;
		k = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1 && k < 20) begin
			k++;
			@(posedge clk);
		end
		if (k == 20)
			fails++;
		rd = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wait_mode(input swc_state_t m, input int max);
		n = 0;
		@(negedge clk);
		while (mode !== m && n < max) begin
			n++;
			@(negedge clk);
		end
		chk({27'h0, mode}, {27'h0, m});
	endtask : wait_mode

	task automatic enter(input logic [7:0] c, input swc_state_t m);
		repeat (70) @(posedge clk);
		apb(1'b1, `SWC_OFF_CTRL, {24'h0, c});
		apb(1'b1, `SWC_OFF_CMD, 32'h1);
		wait_mode(m, 4);
	endtask : enter

	task automatic wake(input logic [3:0] s);
		@(posedge clk);
		src <= s;
		raise <= 1'b1;
		@(posedge clk);
		raise <= 1'b0;
	endtask : wake

	task automatic to_src(input logic [3:0] s);
		@(posedge clk);
		src <= s;
	endtask : to_src

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic t_regs();
		apb(1'b0, `SWC_OFF_CTRL, 0);
		chk(rd, 0);
		apb(1'b0, `SWC_OFF_STATUS, 0);
		chk(rd & 32'h0FF, 32'h041);
		apb(1'b0, 8'h10, 0);
		chk({rd[30:0], e}, 1);
		apb(1'b0, `SWC_OFF_CMD, 0);
		chk({31'h0, e}, 1);
		// Kind 3 selects no standby
		apb(1'b1, `SWC_OFF_CTRL, 32'h03);
		apb(1'b1, `SWC_OFF_CMD, 32'h1);
		wait_mode(SWC_RUN, 1);
	endtask : t_regs

	task automatic t_idle();
		for (int s = 0; s < 9; s++) begin
			enter(8'h00, SWC_IDLE);
			wake(s[3:0]);
			wait_mode(SWC_RUN, 20);
			chk({31'h0, take}, 1);
		end
	endtask : t_idle

	task automatic t_mask();
		@(posedge clk);
		ie <= 1'b0;
		lvl <= 3'h2;
		msk <= 3'h2;
		enter(8'h00, SWC_IDLE);
		wake(4'h3);
		repeat (20) @(negedge clk);
		chk({27'h0, mode}, {27'h0, SWC_IDLE});
		@(posedge clk);
		lvl <= 3'h3;
		wait_mode(SWC_RUN, 10);
		chk({30'h0, take, resume}, 1);
		@(posedge clk);
		ie <= 1'b1;
	endtask : t_mask

	task automatic t_sleep();
		enter(8'h05, SWC_SLEEP);
		wake(4'h8);
		repeat (20) @(negedge clk);
		chk({27'h0, mode}, {27'h0, SWC_SLEEP});
		to_src(4'h3);
		repeat (20) @(negedge clk);
		chk({27'h0, mode}, {27'h0, SWC_SLEEP});
		to_src(4'h7);
		wait_mode(SWC_WARM, 10);
		chk({31'h0, sclk}, 0);
		wait_mode(SWC_RUN, 100);
		chk(n >= 11 && n <= 40, 1);
		enter(8'h85, SWC_SLEEP);
		wake(4'h8);
		wait_mode(SWC_WARM, 10);
		wait_mode(SWC_RUN, 100);
		apb(1'b0, `SWC_OFF_CTRL, 0);
		chk(rd, 32'h85);
	endtask : t_sleep

	task automatic t_stop();
		int edges;
		for (int i = 0; i < 2; i++) begin
			edges = 1 << (8 + 2 * i);
			enter({3'h0, i[0], 2'h2 + i[1:0], 2'h2}, SWC_STOP);
			chk({28'h0, hosc, lsc, hold, flt}, {30'h0, i[0], !i[0]});
			wake(4'h2);
			repeat (20) @(negedge clk);
			chk({27'h0, mode}, {27'h0, SWC_STOP});
			to_src(4'h0);
			wait_mode(SWC_WARM, 10);
			wait_mode(SWC_RUN, 5000);
			chk(n >= (edges - 1) * 4 && n <= edges * 4 + 20, 1);
			apb(1'b0, `SWC_OFF_STATUS, 0);
			chk({31'h0, rd[`SWC_ST_SLOW]}, 0);
		end
	endtask : t_stop

	task automatic t_slow();
		enter(8'h22, SWC_STOP);
		chk({31'h0, lsc}, 1);
		wake(4'h1);
		wait_mode(SWC_RUN, 8);
		apb(1'b0, `SWC_OFF_STATUS, 0);
		chk({31'h0, rd[`SWC_ST_SLOW]}, 1);
		apb(1'b1, `SWC_OFF_CTRL, 32'h60);
		apb(1'b1, `SWC_OFF_CTRL, 32'h00);
		wait_mode(SWC_WARM, 10);
		wait_mode(SWC_RUN, 100);
	endtask : t_slow

	task automatic t_pin();
		apb(1'b1, `SWC_OFF_BACKUP, 32'h5AA5C33C);
		enter(8'h1A, SWC_STOP);
		@(posedge clk);
		ext_rst_n <= 1'b0;
		repeat (8) @(posedge clk);
		ext_rst_n <= 1'b1;
		wait_mode(SWC_RUN, 10);
		n = 0;
		while (init !== 1'b1 && n < 10) begin
			n++;
			@(posedge clk);
		end
		chk({31'h0, init}, 1);
		apb(1'b0, `SWC_OFF_CTRL, 0);
		chk(rd, 0);
		apb(1'b0, `SWC_OFF_BACKUP, 0);
		chk(rd, 32'h5AA5C33C);
		apb(1'b0, `SWC_OFF_STATUS, 0);
		chk({31'h0, rd[`SWC_ST_BY_RESET]}, 1);
	endtask : t_pin

	// ---------------------------------------------------------------
	// Run
	// ---------------------------------------------------------------
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			fails++;
			wrap_up();
		end
	end

	initial begin
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		t_regs();
		t_idle();
		t_mask();
		t_sleep();
		t_stop();
		t_slow();
		t_pin();
		wrap_up();
	end
endmodule : standby_wakeup_warmup_control_test

// *** testbench/swc_core_model.sv ***
`timescale 1ns/100ps

module swc_core_model (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic srst_i,
	// Bench request
	input wire logic raise_i,
	// Release from block
	input wire logic take_handler_i,
	input wire logic resume_next_i,
	// Oscillator and wake level
	output logic osc_clk_o,
	output logic wake_level_o
);
	logic div_r;

	// Oscillator, four core cycles a period
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			div_r <= 1'b0;
			osc_clk_o <= 1'b0;
		end else begin
			div_r <= !div_r;
			if (div_r) begin
				osc_clk_o <= !osc_clk_o;
			end
		end
	end

	// Level held until the block releases the core (handler or resume)
	always_ff @(posedge core_clk_i) begin
		if (srst_i || take_handler_i || resume_next_i) begin
			wake_level_o <= 1'b0;
		end else if (raise_i) begin
			wake_level_o <= 1'b1;
		end
	end
endmodule : swc_core_model

// *** testbench/swc_standby_ctrl_props.sv ***
`timescale 1ns/100ps

module swc_standby_ctrl_props
	import swc_pkg::*;
(
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic srst_i,
	// Bus
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pready_o,
	input wire logic pslverr_o,
	// Wake side
	input wire logic ext_rst_n_i,
	input wire logic [9:0] timer_irqs_i,
	input wire logic [2:0] irq_level_i,
	input wire logic [2:0] irq_mask_i,
	// Outputs watched
	input wire logic take_handler_o,
	input wire logic resume_next_o,
	input wire logic sys_clk_en_o,
	input wire logic hosc_run_o,
	input wire logic low_speed_clock_run_o,
	input wire logic pin_drive_hold_o,
	input wire logic pin_float_o,
	input wire swc_state_t mode_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (srst_i);

	apb_answer_a: assert property (psel_i && !penable_i |=> pready_o)
		else $error("no ready after setup");
	err_ready_a: assert property (pslverr_o |-> pready_o)
		else $error("error without ready");
	clk_gate_a: assert property (sys_clk_en_o == (mode_o == SWC_RUN))
		else $error("system clock enable off mode");
	stop_osc_a: assert property (mode_o == SWC_STOP |-> !hosc_run_o)
		else $error("oscillator on in stop");
	stop_pins_a: assert property (pin_drive_hold_o || pin_float_o |->
		mode_o == SWC_STOP && !(pin_drive_hold_o && pin_float_o))
		else $error("pin state outside stop");
	lsc_stop_a: assert property (!low_speed_clock_run_o |-> mode_o == SWC_STOP)
		else $error("low speed clock off outside stop");
	release_pulse_a: assert property (take_handler_o || resume_next_o |->
		mode_o == SWC_RUN && $past(mode_o) != SWC_RUN && !(take_handler_o && resume_next_o))
		else $error("release pulse misplaced");
	idle_wake_a: assert property (mode_o == SWC_IDLE && timer_irqs_i != 0 && irq_level_i > irq_mask_i |=>
		mode_o == SWC_RUN)
		else $error("idle not released by timer");
	mask_hold_a: assert property (mode_o == SWC_IDLE && irq_level_i <= irq_mask_i && ext_rst_n_i
		&& $past(ext_rst_n_i) && $past(ext_rst_n_i, 2) && $past(ext_rst_n_i, 3) |=> mode_o == SWC_IDLE)
		else $error("masked level released idle");
endmodule : swc_standby_ctrl_props

bind swc_standby_ctrl swc_standby_ctrl_props u_props (.core_clk_i, .srst_i, .psel_i, .penable_i, .pready_o, .pslverr_o,
	.ext_rst_n_i, .timer_irqs_i, .irq_level_i, .irq_mask_i, .take_handler_o, .resume_next_o, .sys_clk_en_o,
	.hosc_run_o, .low_speed_clock_run_o, .pin_drive_hold_o, .pin_float_o, .mode_o);
